/* logic/dmd_defs.svh */
// Constants for the disk microcode instruction decoder
`ifndef DMD_DEFS_SVH
`define DMD_DEFS_SVH
`define DMD_RST_PC 9'h000
`define DMD_RST_RA 9'h000
`define DMD_RST_BYTE 8'h00
`define DMD_CARRY_BIT 7
`define DMD_OPC_NOP 4'h0
`define DMD_OPC_B2M 4'h1
`define DMD_OPC_M2B 4'h2
`define DMD_OPC_ADD 4'h3
`define DMD_OPC_OR 4'h4
`define DMD_OPC_XOR 4'h5
`define DMD_OPC_ADC 4'h6
`define DMD_OPC_AND 4'h7
`define DMD_OP_UB_LO 8'h88
`define DMD_OP_UB_HI 8'h89
`define DMD_OP_RA_LO 8'h8C
`define DMD_OP_RA_HI 8'h8D
`define DMD_OP_CTL1 8'hEC
`define DMD_OP_CTL2 8'hFC
`define DMD_OPC_ORI 4'hC
`define DMD_OPC_XORI 4'hD
`define DMD_OPC_ADCI 4'hE
`define DMD_OPC_ANDI 4'hF
`define DMD_IMM_SUB 2'h2
`define DMD_BZ_SUB 2'h3
`define DMD_OPC_BEQ 4'h8
`define DMD_OPC_BNE 4'h9
`define DMD_OPC_BT 4'hA
`define DMD_OPC_BF 4'hB
`define DMD_ID_STAY 2'h0
`define DMD_ID_INC 2'h1
`define DMD_ID_DEC 2'h2
`define DMD_ID_REG 2'h3
`define DMD_DELAY_MS 10
`define DMD_CLK_HZ 25000000
`endif

/* logic/dmd_pkg.sv */
// Types for the disk microcode instruction decoder
package dmd_pkg;
  typedef enum logic [1:0] {
    DMD_REG_ACC,
    DMD_REG_HOST,
    DMD_REG_ST0,
    DMD_REG_ST1
  } dmd_reg_e;
  typedef enum logic [1:0] {
    DMD_ALU_ADD,
    DMD_ALU_OR,
    DMD_ALU_XOR,
    DMD_ALU_AND
  } dmd_alu_e;
endpackage : dmd_pkg

/* logic/dmd_alu.sv */
// Eight-bit ALU of the microcode engine
`timescale 1ns/1ps
module dmd_alu (
  // Operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  input wire dmd_pkg::dmd_alu_e func_i,
  // Result
  output logic [7:0] y_o,
  output logic carry_o
);
  import dmd_pkg::*;
  logic [8:0] sum;
  // Carry is only meaningful for the add function
  always_comb begin
    sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
    carry_o = 1'b0;
    case (func_i)
      DMD_ALU_ADD: begin
        y_o = sum[7:0];
        carry_o = sum[8];
      end
      DMD_ALU_OR: y_o = a_i | b_i;
      DMD_ALU_XOR: y_o = a_i ^ b_i;
      DMD_ALU_AND: y_o = a_i & b_i;
      default: y_o = a_i;
    endcase
  end
endmodule : dmd_alu

/* logic/dmd_delay.sv */
// Retriggerable millisecond delay timer
`timescale 1ns/1ps
`include "dmd_defs.svh"
module dmd_delay #(
  parameter int unsigned CYCLES = (`DMD_DELAY_MS * (`DMD_CLK_HZ / 1000))
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic start_i,
  // Status
  output logic active_o
);
  typedef struct packed {
    logic [31:0] cnt;
  } dmd_dly_s;
  dmd_dly_s s_q, s_d;
  // A zero count would never raise the active flag
  if (CYCLES < 1) begin : g_bad_cycles
    $error("delay count must be at least one cycle");
  end
  // A new start reloads the full count
  always_comb begin
    s_d = s_q;
    if (start_i) begin
      s_d.cnt = CYCLES;
    end else if (s_q.cnt != 32'h0000_0000) begin
      s_d.cnt = s_q.cnt - 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign active_o = (s_q.cnt != 32'h0000_0000);
endmodule : dmd_delay

/* logic/dmd_decoder.sv */
// Microinstruction decoder and execution core of the disk microcode engine
// Summary of operation
// - Instruction is opcode in upper byte, operand in lower byte
// - Register ops combine RAM byte and chosen register, update address
// - No-operation only advances the instruction counter
// - Register-to-memory stores register in RAM, then steps address
// - Memory-to-register loads RAM byte to register, then steps address
// - Add without carry, result to RAM or register per coding
// - Add with carry adds the stored carry bit
// - OR, XOR, AND with RAM byte, then address update
// - Immediate ops combine register with operand, write back to register
// - Zero/nonzero branch tests whole register, target in operand
// - True/false branch tests masked nibble bits, target in low nibble
// - Equal/not-equal mask branch compares chosen nibble with mask
// - 88YY/89YY load nine-bit counter from operand and opcode bit 8
// - 8CXX/8DXX preset nine-bit RAM address
// - Control class drives lines directly, no ALU, no register change
// - EC group: read, write gate, busy, format, dir, CRC, step, load
// - FC group: drives 3,2,1, clear inop, host strobe, delay start
// - Register select: accumulator, host byte, status zero, status one
// - Address coding: stay, up, down, or result to register and up
// - Carry comes from and returns to status one bit 7
// - Register opcodes 1 to 7 in upper nibble
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dmd_defs.svh"
module dmd_decoder #(
  parameter int unsigned DELAY_CYCLES =
    (`DMD_DELAY_MS * (`DMD_CLK_HZ / 1000))
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Microprogram store
  output logic [8:0] pc_o,
  input wire logic [15:0] instr_i,
  // Data RAM
  output logic [8:0] ram_addr_o,
  input wire logic [7:0] ram_rdata_i,
  output logic [7:0] ram_wdata_o,
  output logic ram_we_o,
  // Host byte and status sources (pins)
  input wire logic host_load_i,
  input wire logic [7:0] host_byte_i,
  input wire logic [7:0] st0_pins_i,
  input wire logic [6:0] st1_pins_i,
  // Register views
  output logic [7:0] acc_o,
  output logic [7:0] host_reg_o,
  output logic [7:0] status_register_zero_o,
  output logic [7:0] status_register_one_o,
  // First control group
  output logic read_gate_on_o,
  output logic write_gate_on_o,
  output logic host_busy_flag_o,
  output logic format_select_o,
  output logic head_direction_select_o,
  output logic crc_preset_o,
  output logic head_step_pulse_o,
  output logic head_load_request_o,
  // Second control group
  output logic drive_three_sel_o,
  output logic drive_two_sel_o,
  output logic drive_one_sel_o,
  output logic clear_file_inoperable_o,
  output logic host_strobe_o,
  output logic delay_active_o
);
  import dmd_pkg::*;

  typedef struct packed {
    logic [8:0] pc;
    logic [8:0] ra;
    logic [7:0] acc;
    logic [7:0] host;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] wdata;
    logic we;
    logic [8:0] wa;
    logic [7:0] ctl1;
    logic [5:0] ctl2;
    logic [7:0] st0_m;
    logic [7:0] st0_s;
    logic [6:0] st1_m;
    logic [6:0] st1_s;
    logic hl_m;
    logic hl_s;
    logic [7:0] hb_m;
    logic [7:0] hb_s;
  } dmd_core_s;

  dmd_core_s s_q, s_d;

  logic [7:0] opc;
  logic [7:0] opd;
  logic [3:0] hi;
  logic [1:0] id;
  dmd_reg_e rsel;
  logic [7:0] breg;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  dmd_alu_e alu_fn;
  logic [7:0] alu_y;
  logic alu_cout;
  logic dly_start;
  logic [8:0] pc_inc;

  // Picks the working register named by the two select bits
  function automatic logic [7:0] reg_pick(input dmd_reg_e sel,
      input logic [7:0] a, input logic [7:0] k,
      input logic [7:0] z, input logic [7:0] o);
    case (sel)
      DMD_REG_ACC: reg_pick = a;
      DMD_REG_HOST: reg_pick = k;
      DMD_REG_ST0: reg_pick = z;
      DMD_REG_ST1: reg_pick = o;
      default: reg_pick = a;
    endcase
  endfunction : reg_pick

  // Applies the address-update coding to the RAM pointer
  function automatic logic [8:0] ra_step(input logic [1:0] code,
      input logic [8:0] ra);
    case (code)
      `DMD_ID_INC: ra_step = ra + 9'h001;
      `DMD_ID_DEC: ra_step = ra - 9'h001;
      `DMD_ID_REG: ra_step = ra + 9'h001;
      default: ra_step = ra;
    endcase
  endfunction : ra_step

  // Field split of the fetched word
  assign opc = instr_i[15:8];
  assign opd = instr_i[7:0];
  assign hi = opc[7:4];
  assign id = opc[3:2];
  assign rsel = dmd_reg_e'(opc[1:0]);
  assign breg = reg_pick(rsel, s_q.acc, s_q.host, s_q.st0, s_q.st1);
  assign pc_inc = s_q.pc + 9'h001;

  // ALU steering: register class uses RAM, immediates use the operand
  always_comb begin
    alu_a = breg;
    alu_b = (hi >= `DMD_OPC_ORI) ? opd : ram_rdata_i;
    alu_cin = 1'b0;
    case (hi)
      `DMD_OPC_ADD: alu_fn = DMD_ALU_ADD;
      `DMD_OPC_ADC, `DMD_OPC_ADCI: begin
        alu_fn = DMD_ALU_ADD;
        alu_cin = s_q.st1[`DMD_CARRY_BIT];
      end
      `DMD_OPC_OR, `DMD_OPC_ORI: alu_fn = DMD_ALU_OR;
      `DMD_OPC_XOR, `DMD_OPC_XORI: alu_fn = DMD_ALU_XOR;
      `DMD_OPC_AND, `DMD_OPC_ANDI: alu_fn = DMD_ALU_AND;
      default: alu_fn = DMD_ALU_OR;
    endcase
  end

  dmd_alu u_alu (
    .a_i(alu_a),
    .b_i(alu_b),
    .carry_i(alu_cin),
    .func_i(alu_fn),
    .y_o(alu_y),
    .carry_o(alu_cout)
  );

  assign dly_start = (opc == `DMD_OP_CTL2) && opd[5];

  dmd_delay #(
    .CYCLES(DELAY_CYCLES)
  ) u_delay (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(dly_start),
    .active_o(delay_active_o)
  );

  // Next-state logic: one instruction executes per clock
  always_comb begin
    logic [7:0] res;
    logic wr_reg;
    logic carry_upd;
    logic [3:0] nib;
    res = alu_y;
    wr_reg = 1'b0;
    carry_upd = 1'b0;
    nib = opc[2] ? breg[7:4] : breg[3:0];
    s_d = s_q;
    s_d.pc = pc_inc;
    s_d.we = 1'b0;
    s_d.wa = s_q.ra; // Write address is the pointer before its update
    // Control strobes last one instruction; a pulse per issued word
    s_d.ctl1 = `DMD_RST_BYTE;
    s_d.ctl2 = 6'h00;
    // Pin inputs pass two flops before use
    s_d.st0_m = st0_pins_i;
    s_d.st0_s = s_q.st0_m;
    s_d.st1_m = st1_pins_i;
    s_d.st1_s = s_q.st1_m;
    s_d.hl_m = host_load_i;
    s_d.hl_s = s_q.hl_m;
    s_d.hb_m = host_byte_i;
    s_d.hb_s = s_q.hb_m;
    if (hi >= `DMD_OPC_B2M && hi <= `DMD_OPC_AND) begin
      // Register class, opcodes 1 to 7
      if (hi == `DMD_OPC_M2B) begin
        res = ram_rdata_i;
        wr_reg = 1'b1;
      end else if (hi == `DMD_OPC_B2M) begin
        s_d.wdata = breg;
        s_d.we = 1'b1;
      end else begin
        carry_upd = (hi == `DMD_OPC_ADC);
        if (id == `DMD_ID_REG) begin
          wr_reg = 1'b1;
        end else begin
          s_d.wdata = alu_y;
          s_d.we = 1'b1;
        end
      end
      s_d.ra = ra_step(id, s_q.ra);
    end else if (hi >= `DMD_OPC_ORI && id == `DMD_IMM_SUB) begin
      wr_reg = 1'b1;
      carry_upd = (hi == `DMD_OPC_ADCI);
    end else if (hi >= `DMD_OPC_ORI && id == `DMD_BZ_SUB &&
        hi != `DMD_OPC_ADCI && hi != `DMD_OPC_ANDI) begin
      // Zero and nonzero branches replace the low eight bits
      if ((breg == 8'h00) == (hi == `DMD_OPC_ORI)) begin
        s_d.pc = {s_q.pc[8], opd};
      end
    end else if (hi >= `DMD_OPC_BEQ && hi <= `DMD_OPC_BF &&
        id[1] == 1'b0) begin
      // Short mask branches keep the upper counter bits
      if ((hi == `DMD_OPC_BEQ && nib == opd[7:4]) ||
          (hi == `DMD_OPC_BNE && nib != opd[7:4]) ||
          (hi == `DMD_OPC_BT && (nib & opd[7:4]) != 4'h0) ||
          (hi == `DMD_OPC_BF && (~nib & opd[7:4]) != 4'h0)) begin
        s_d.pc = {s_q.pc[8:4], opd[3:0]};
      end
    end else if (opc == `DMD_OP_UB_LO || opc == `DMD_OP_UB_HI) begin
      s_d.pc = {opc[0], opd};
    end else if (opc == `DMD_OP_RA_LO || opc == `DMD_OP_RA_HI) begin
      s_d.ra = {opc[0], opd};
    end else if (opc == `DMD_OP_CTL1) begin
      s_d.ctl1 = opd;
    end else if (opc == `DMD_OP_CTL2) begin
      s_d.ctl2 = opd[5:0];
    end
    // Status registers follow their pins except where software writes
    s_d.st0 = s_q.st0_s;
    s_d.st1 = {s_q.st1[`DMD_CARRY_BIT], s_q.st1_s};
    if (s_q.hl_s) begin
      s_d.host = s_q.hb_s;
    end
    if (wr_reg) begin
      case (rsel)
        DMD_REG_ACC: s_d.acc = res;
        DMD_REG_HOST: s_d.host = res;
        DMD_REG_ST0: s_d.st0 = res;
        DMD_REG_ST1: s_d.st1 = res;
        default: s_d.acc = res;
      endcase
    end
    // Stored carry wins over a register write to the same bit
    if (carry_upd) begin
      s_d.st1[`DMD_CARRY_BIT] = alu_cout;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs all come from flops
  assign pc_o = s_q.pc;
  assign ram_addr_o = s_q.we ? s_q.wa : s_q.ra;
  assign ram_wdata_o = s_q.wdata;
  assign ram_we_o = s_q.we;
  assign acc_o = s_q.acc;
  assign host_reg_o = s_q.host;
  assign status_register_zero_o = s_q.st0;
  assign status_register_one_o = s_q.st1;
  assign read_gate_on_o = s_q.ctl1[0];
  assign write_gate_on_o = s_q.ctl1[1];
  assign host_busy_flag_o = s_q.ctl1[2];
  assign format_select_o = s_q.ctl1[3];
  assign head_direction_select_o = s_q.ctl1[4];
  assign crc_preset_o = s_q.ctl1[5];
  assign head_step_pulse_o = s_q.ctl1[6];
  assign head_load_request_o = s_q.ctl1[7];
  assign drive_three_sel_o = s_q.ctl2[0];
  assign drive_two_sel_o = s_q.ctl2[1];
  assign drive_one_sel_o = s_q.ctl2[2];
  assign clear_file_inoperable_o = s_q.ctl2[3];
  assign host_strobe_o = s_q.ctl2[4];
endmodule : dmd_decoder

/* bench/dmd_env_model.sv */
// Microprogram store and data RAM model around the decoder
`timescale 1ns/1ps
module dmd_env_model (
  // Clock
  input wire logic clk_i,
  // Fetch
  input wire logic [8:0] pc_i,
  output logic [15:0] instr_o,
  // Data RAM
  input wire logic [8:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  input wire logic ram_we_i,
  output logic [7:0] ram_rdata_o
);
  logic [15:0] rom [512];
  logic [7:0] ram [512];
  // Reads are combinational because the decoder fetches within the cycle
  assign instr_o = rom[pc_i];
  assign ram_rdata_o = ram[ram_addr_i];
  // Write lands on the edge that closes the strobe cycle
  always @(posedge clk_i) begin
    if (ram_we_i) begin
      ram[ram_addr_i] <= ram_wdata_i;
    end
  end
endmodule : dmd_env_model

/* bench/dmd_decoder_asserts.sv */
// Port-level checks of the microinstruction decoder
`timescale 1ns/1ps
module dmd_decoder_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fetch and RAM
  input wire logic [8:0] pc_o,
  input wire logic [15:0] instr_i,
  input wire logic [8:0] ram_addr_o,
  input wire logic [7:0] ram_wdata_o,
  input wire logic ram_we_o,
  input wire logic [7:0] acc_o,
  // Control lines
  input wire logic read_gate_on_o,
  input wire logic write_gate_on_o,
  input wire logic host_busy_flag_o,
  input wire logic format_select_o,
  input wire logic head_direction_select_o,
  input wire logic crc_preset_o,
  input wire logic head_step_pulse_o,
  input wire logic head_load_request_o,
  input wire logic drive_three_sel_o,
  input wire logic drive_two_sel_o,
  input wire logic drive_one_sel_o,
  input wire logic clear_file_inoperable_o,
  input wire logic host_strobe_o
);
  // Reset seen one edge late, so a word fetched in reset starts no check
  logic rst_seen_q;
  always_ff @(posedge clk_i) begin
    rst_seen_q <= rst_b_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !rst_seen_q);
  // Control lines gathered in operand bit order
  wire [7:0] ctl1 = {head_load_request_o, head_step_pulse_o, crc_preset_o,
    head_direction_select_o, format_select_o, host_busy_flag_o,
    write_gate_on_o, read_gate_on_o};
  wire [4:0] ctl2 = {host_strobe_o, clear_file_inoperable_o,
    drive_one_sel_o, drive_two_sel_o, drive_three_sel_o};
  property p_nop;
    instr_i == 16'h0000 |=> pc_o == $past(pc_o) + 9'h001 && !ram_we_o &&
      $stable(acc_o);
  endproperty
  a_nop: assert property (p_nop) else $error("nop side effect");
  property p_ub;
    instr_i[15:9] == 7'h44 |=> pc_o == $past(instr_i[8:0]);
  endproperty
  a_ub: assert property (p_ub) else $error("jump target wrong");
  property p_ld;
    instr_i[15:9] == 7'h46 |=> ram_addr_o == $past(instr_i[8:0]);
  endproperty
  a_ld: assert property (p_ld) else $error("pointer preset wrong");
  property p_c1;
    instr_i[15:8] == 8'hEC |=> ctl1 == $past(instr_i[7:0]) && $stable(acc_o);
  endproperty
  a_c1: assert property (p_c1) else $error("group one wrong");
  property p_c2;
    instr_i[15:8] == 8'hFC |=> ctl2 == $past(instr_i[4:0]);
  endproperty
  a_c2: assert property (p_c2) else $error("group two wrong");
  property p_b2m;
    instr_i[15:12] == 4'h1 && !(&instr_i[11:10]) && instr_i[9:8] == 2'h0
      |=> ram_we_o && ram_wdata_o == $past(acc_o);
  endproperty
  a_b2m: assert property (p_b2m) else $error("store wrong");
  property p_ori;
    instr_i[15:8] == 8'hC8 |=> acc_o == ($past(acc_o) | $past(instr_i[7:0]));
  endproperty
  a_ori: assert property (p_ori) else $error("immediate or wrong");
  property p_bz;
    instr_i[15:8] == 8'hCC |=> pc_o == ($past(acc_o) == 8'h00 ?
      {$past(pc_o[8]), $past(instr_i[7:0])} : $past(pc_o) + 9'h001);
  endproperty
  a_bz: assert property (p_bz) else $error("zero branch wrong");
endmodule : dmd_decoder_asserts
bind dmd_decoder dmd_decoder_asserts u_chk (.*);

/* bench/tb_disk_microcode_instruction_decoder.sv */
// Self-checking bench for the disk microcode instruction decoder
`timescale 1ns/1ps
module tb_disk_microcode_instruction_decoder;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic host_load_i = 1'b0;
  logic [7:0] host_byte_i = 8'h00;
  logic [7:0] st0_pins_i = 8'h00;
  logic [6:0] st1_pins_i = 7'h00;
  wire [8:0] pc_o;
  wire [8:0] ram_addr_o;
  wire [15:0] instr;
  wire [7:0] rdata, wdata, acc_o, host_o, st0_o, st1_o, c1;
  wire [4:0] c2;
  wire we, dly;
  logic [15:0] q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  // Free-running 25 MHz clock
  always #20 clk_i = ~clk_i;
  dmd_decoder #(.DELAY_CYCLES(5)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .pc_o(pc_o), .instr_i(instr),
    .ram_addr_o(ram_addr_o), .ram_rdata_i(rdata), .ram_wdata_o(wdata),
    .ram_we_o(we), .host_load_i(host_load_i), .host_byte_i(host_byte_i),
    .st0_pins_i(st0_pins_i), .st1_pins_i(st1_pins_i), .acc_o(acc_o),
    .host_reg_o(host_o), .status_register_zero_o(st0_o),
    .status_register_one_o(st1_o), .read_gate_on_o(c1[0]),
    .write_gate_on_o(c1[1]), .host_busy_flag_o(c1[2]),
    .format_select_o(c1[3]), .head_direction_select_o(c1[4]),
    .crc_preset_o(c1[5]), .head_step_pulse_o(c1[6]),
    .head_load_request_o(c1[7]), .drive_three_sel_o(c2[0]),
    .drive_two_sel_o(c2[1]), .drive_one_sel_o(c2[2]),
    .clear_file_inoperable_o(c2[3]), .host_strobe_o(c2[4]),
    .delay_active_o(dly));
  dmd_env_model env (
    .clk_i(clk_i), .pc_i(pc_o), .instr_o(instr), .ram_addr_i(ram_addr_o),
    .ram_wdata_i(wdata), .ram_we_i(we), .ram_rdata_o(rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Every unused step traps in a jump to itself, so a stray branch shows
  task automatic clear();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 512; a++) begin
      env.rom[a] = {7'h44, 9'(a)};
      env.ram[a] = 8'h00;
    end
  endtask : clear
  task automatic load(input logic [8:0] b);
    foreach (q[i]) env.rom[b + 9'(i)] = q[i];
  endtask : load
  task automatic go(input int n);
    rst_b_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : go
  task automatic t_imm();
    clear();
    q = {16'hC8A5, 16'hF80F, 16'hD8FF, 16'hE807, 16'hE800, 16'h0000,
      16'hCC0A, 16'hDC20};
    load(9'h000);
    env.rom[9'h020] = 16'h8D05;
    go(12);
    chk(16'(acc_o), 16'h0002);
    chk(16'(pc_o), 16'h0021);
    chk(16'(ram_addr_o), 16'h0105);
  endtask : t_imm
  task automatic t_ram();
    clear();
    env.ram[9'h011] = 8'h0F;
    env.ram[9'h012] = 8'hF0;
    env.ram[9'h013] = 8'hFF;
    q = {16'h8C10, 16'hC83C, 16'h1400, 16'h0000, 16'h3C00, 16'h4800,
      16'h0000, 16'h2400, 16'h7000, 16'h0000, 16'h5C00, 16'h6C00};
    load(9'h000);
    go(14);
    chk(16'(env.ram[9'h010]), 16'h003C);
    chk(16'(env.ram[9'h012]), 16'h000B);
    chk(16'(acc_o), 16'h0003);
    chk(16'(st1_o), 16'h0080);
    chk(16'(ram_addr_o), 16'h0014);
    chk(16'(pc_o), 16'h000C);
  endtask : t_ram
  task automatic t_mask();
    clear();
    env.rom[9'h000] = 16'h8930;
    env.rom[9'h130] = 16'hC85A;
    env.rom[9'h131] = 16'h8454;
    env.rom[9'h134] = 16'h80A7;
    env.rom[9'h137] = 16'hA02A;
    env.rom[9'h13A] = 16'hB05C;
    env.rom[9'h13C] = 16'h90AF;
    go(10);
    chk(16'(pc_o), 16'h013D);
  endtask : t_mask
  task automatic t_ctl();
    clear();
    for (int i = 0; i < 8; i++) begin
      env.rom[i] = {8'hEC, 8'h01 << i};
      env.rom[8 + i] = {8'hFC, 8'h01 << i};
    end
    go(1);
    for (int k = 0; k < 16; k++) begin
      chk(16'(c1), k < 8 ? 16'h0001 << k : 16'h0000);
      chk(16'(c2), (k > 7 && k < 13) ? 16'h0001 << (k - 8) : 16'h0);
      chk(16'(acc_o), 16'h0000);
      if (k == 14) begin
        chk(16'(dly), 16'h0001);
      end
      @(posedge clk_i);
      #1;
    end
    repeat (8) @(posedge clk_i);
    #1;
    chk(16'(dly), 16'h0000);
  endtask : t_ctl
  // Host byte arrives while the program idles, then is combined and stored
  task automatic t_host();
    clear();
    host_load_i <= 1'b1;
    host_byte_i <= 8'hC3;
    st0_pins_i <= 8'h96;
    st1_pins_i <= 7'h35;
    q = {16'h0000, 16'h0000, 16'h0000, 16'hC90C, 16'h1100};
    load(9'h001);
    go(6);
    chk(16'(host_o), 16'h00C3);
    chk(16'(st0_o), 16'h0096);
    chk(16'(st1_o[6:0]), 16'h0035);
    @(posedge clk_i);
    host_load_i <= 1'b0;
    env.rom[9'h000] <= 16'h0000;
    repeat (7) @(posedge clk_i);
    #1;
    chk(16'(host_o), 16'h00CF);
    chk(16'(env.ram[9'h000]), 16'h00CF);
    chk(16'(pc_o), 16'h0006);
  endtask : t_host
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // Main sequence after the power-on reset
  initial begin
    repeat (4) @(posedge clk_i);
    t_imm();
    t_ram();
    t_mask();
    t_ctl();
    t_host();
    final_report();
  end
  // Watchdog well beyond the roughly ninety cycles the tests need
  initial begin
    #50000;
    n_mismatch++;
    final_report();
  end
endmodule : tb_disk_microcode_instruction_decoder
